// ### include/lse_pkg.sv
// Constants, item layout and state codes for the LIN slave response engine
package lse_pkg;
   localparam int ID_W = 6;
   localparam int LEN_W = 4;
   localparam int DATA_W = 64;
   localparam int ERR_W = 3;
   localparam int NUM_ID = 64;
   localparam int FIFO_DEPTH = 4;
   localparam logic [LEN_W-1:0] MAX_LEN = 4'h8;
   localparam logic [LEN_W-1:0] LEN_RST = 4'h0;
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   // Item: {kind, id, len, data, err}, err in the low bits
   localparam int IT_ERR_LSB = 0;
   localparam int IT_DATA_LSB = IT_ERR_LSB + ERR_W;
   localparam int IT_LEN_LSB = IT_DATA_LSB + DATA_W;
   localparam int IT_ID_LSB = IT_LEN_LSB + LEN_W;
   localparam int IT_KIND_LSB = IT_ID_LSB + ID_W;
   localparam int ITEM_W = IT_KIND_LSB + 1;
   localparam logic KIND_FULL = 1'b0;
   localparam logic KIND_ERR = 1'b1;
   typedef enum logic [1:0] {
      TX_BREAK = 2'b00,
      TX_SYNC = 2'b01,
      TX_ID = 2'b10,
      TX_DATA = 2'b11
   } lse_tx_e;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_HTX = 3'b001,
      S_PUB = 3'b010,
      S_SUB = 3'b011,
      S_PUSH = 3'b100
   } lse_state_e;
endpackage

// ### rtl/lse_fifo.sv
// Shift-register FIFO whose head sits in a flip-flop
`timescale 1ns/1ps
module lse_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic core_clk_i, // Core clock
   input wire logic rstn_i, // Async reset, active low
   input wire logic in_valid_i, // Write side valid
   output logic in_ready_o, // Write side ready
   input wire logic [WIDTH-1:0] in_data_i, // Write side data
   output logic out_valid_o, // Head valid, registered
   input wire logic out_ready_i, // Read side ready
   output logic [WIDTH-1:0] out_data_o // Head item, registered
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [CW-1:0] ONE = CW'(1);
   logic [CW-1:0] cnt_q;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push;
   logic pop;
   logic [CW-1:0] wr_idx;
   assign in_ready_o = (cnt_q != FULL_CNT);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   // Slot that takes the new word once the shift is accounted for
   assign wr_idx = pop ? cnt_q - ONE : cnt_q;
   assign out_data_o = mem_q[0];
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_slot
         always_ff @(posedge core_clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
               mem_q[g] <= '0;
            else if (push && wr_idx == CW'(g))
               mem_q[g] <= in_data_i;
            else if (pop && g < DEPTH - 1)
               mem_q[g] <= mem_q[(g + 1) % DEPTH];
         end
      end
   endgenerate
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_q <= '0;
         out_valid_o <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
         // Valid drops with the last pop
         out_valid_o <= (cnt_q + CW'(push) - CW'(pop)) != '0;
      end
   end
endmodule // lse_fifo

// ### rtl/lse_response_engine.sv
// LIN slave response engine: response table, frame sequencer, read queue
`timescale 1ns/1ps
module lse_response_engine (
   input wire logic core_clk_i, // 125 MHz core clock
   input wire logic rstn_i, // Async reset, active low
   input wire logic run_i, // Communication started
   input wire logic self_rx_en_i, // Log own published frames
   input wire logic log_err_en_i, // Log bus errors
   input wire logic wr_valid_i, // Host write valid
   output logic wr_ready_o, // Host write ready
   input wire logic wr_full_i, // 1 full frame, 0 response entry
   input wire logic [lse_pkg::ID_W-1:0] wr_id_i, // Write ID
   input wire logic [lse_pkg::LEN_W-1:0] wr_len_i, // Write length code
   input wire logic [lse_pkg::DATA_W-1:0] wr_data_i, // Write data, byte 0 low
   output logic write_ok_o, // Write-success flag
   input wire logic write_ok_clr_i, // Clear write-success
   input wire logic hdr_valid_i, // Header received pulse
   input wire logic [lse_pkg::ID_W-1:0] hdr_id_i, // Received header ID
   input wire logic rx_valid_i, // Response byte received pulse
   input wire logic [7:0] rx_byte_i, // Received response byte
   input wire logic rsp_done_i, // Response ended with good checksum
   input wire logic bus_err_i, // Bus error pulse
   input wire logic [lse_pkg::ERR_W-1:0] bus_err_code_i, // Bus error code
   output logic tx_valid_o, // Field to send
   output logic [1:0] tx_kind_o, // Break, sync, id or data
   output logic [7:0] tx_byte_o, // Field byte
   input wire logic tx_ready_i, // Field taken by bit layer
   output logic rd_valid_o, // Read queue head valid
   input wire logic rd_ready_i, // Host pops head
   output logic [lse_pkg::ITEM_W-1:0] rd_item_o, // Read queue head
   output logic read_avail_o // Read-available flag
);
   localparam int ID_W = lse_pkg::ID_W;
   localparam int LEN_W = lse_pkg::LEN_W;
   localparam int DATA_W = lse_pkg::DATA_W;

   logic [LEN_W-1:0] len_q [lse_pkg::NUM_ID];
   logic [DATA_W-1:0] data_q [lse_pkg::NUM_ID];
   lse_pkg::lse_state_e state_q;
   logic [ID_W-1:0] cur_id_q;
   logic [LEN_W-1:0] cur_len_q;
   logic [LEN_W-1:0] cnt_q;
   logic [DATA_W-1:0] buf_q;
   logic [lse_pkg::ITEM_W-1:0] item_q;
   logic err_seen_q;
   logic pend_hdr_q;
   logic own_q;
   logic wr_ready_q;
   logic write_ok_q;
   logic tx_valid_q;
   logic [1:0] tx_kind_q;
   logic [7:0] tx_byte_q;
   logic [ID_W-1:0] full_id_q;

   logic wr_acc;
   logic ent_acc;
   logic full_acc;
   logic [LEN_W-1:0] tbl_len;
   logic [LEN_W-1:0] sel_len;
   logic [DATA_W-1:0] sel_data;
   logic tx_fire;
   logic err_take;
   logic done_take;
   logic own_end;
   logic pend_d;
   logic own_d;
   logic htx_start;
   logic fifo_in_ready;
   logic [5:0] byte_idx;
   logic [7:0] prot_id;
   logic [lse_pkg::ITEM_W-1:0] err_item;
   logic [lse_pkg::ITEM_W-1:0] sub_item;
   logic [lse_pkg::ITEM_W-1:0] pub_item;

   assign wr_acc = wr_valid_i & wr_ready_q;
   assign ent_acc = wr_acc & ~wr_full_i;
   assign full_acc = wr_acc & wr_full_i;
   // Oversized length codes publish the maximum frame
   assign tbl_len = (wr_len_i > lse_pkg::MAX_LEN) ? lse_pkg::MAX_LEN : wr_len_i;
   assign sel_len = len_q[hdr_id_i];
   assign sel_data = data_q[hdr_id_i];
   assign tx_fire = tx_valid_q & tx_ready_i;
   assign byte_idx = {cnt_q[2:0], 3'h0};
   // Protected identifier with both parity bits
   assign prot_id = {~(cur_id_q[1] ^ cur_id_q[3] ^ cur_id_q[4] ^ cur_id_q[5]),
                     cur_id_q[0] ^ cur_id_q[1] ^ cur_id_q[2] ^ cur_id_q[4],
                     cur_id_q};
   // Only the first error of a frame is acted on
   assign err_take = bus_err_i & ~err_seen_q & (state_q != lse_pkg::S_PUSH);
   assign done_take = rsp_done_i & ~err_take &
                      ((state_q == lse_pkg::S_PUB) | (state_q == lse_pkg::S_SUB));
   // Own frame ends on completion or on its error
   assign own_end = own_q & (err_take | done_take);
   assign htx_start = (state_q == lse_pkg::S_IDLE) & pend_hdr_q & ~hdr_valid_i & ~err_take;
   assign pend_d = full_acc | (pend_hdr_q & ~htx_start);
   assign own_d = htx_start | (own_q & ~own_end);

   assign err_item = {lse_pkg::KIND_ERR, cur_id_q, cnt_q, buf_q, bus_err_code_i};
   assign sub_item = {lse_pkg::KIND_FULL, cur_id_q, cnt_q, buf_q,
                      {lse_pkg::ERR_W{1'b0}}};
   assign pub_item = {lse_pkg::KIND_FULL, cur_id_q, cur_len_q, buf_q,
                      {lse_pkg::ERR_W{1'b0}}};

   // Table write port open whenever the host is accepted
   genvar g;
   generate
      for (g = 0; g < lse_pkg::NUM_ID; g++)
      begin : g_entry
         always_ff @(posedge core_clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               len_q[g] <= lse_pkg::LEN_RST;
               data_q[g] <= '0;
            end
            // Full frame stored as publish entry
            else if (wr_acc && wr_id_i == ID_W'(g))
            begin
               len_q[g] <= (wr_full_i && tbl_len == '0) ? lse_pkg::MAX_LEN : tbl_len;
               data_q[g] <= wr_data_i;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pend_hdr_q <= 1'b0;
         own_q <= 1'b0;
         wr_ready_q <= 1'b0;
         write_ok_q <= 1'b0;
      end
      else
      begin
         pend_hdr_q <= pend_d;
         own_q <= own_d;
         // One full frame in flight; entries also wait behind it
         wr_ready_q <= run_i & ~pend_d & ~own_d & ~wr_acc;
         // Entry write sets the flag; set wins over clear
         write_ok_q <= ent_acc | own_end | (write_ok_q & ~write_ok_clr_i);
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_q <= lse_pkg::S_IDLE;
         cur_id_q <= '0;
         cur_len_q <= '0;
         cnt_q <= '0;
         buf_q <= '0;
         item_q <= '0;
         err_seen_q <= 1'b0;
         tx_valid_q <= 1'b0;
         tx_kind_q <= lse_pkg::TX_BREAK;
         tx_byte_q <= 8'h00;
      end
      else if (err_take)
      begin
         // Abandon the frame, wait for the next header
         err_seen_q <= 1'b1;
         tx_valid_q <= 1'b0;
         // First error logged; a collision arrives here too
         if (log_err_en_i)
         begin
            item_q <= err_item;
            state_q <= lse_pkg::S_PUSH;
         end
         else
            state_q <= lse_pkg::S_IDLE;
      end
      else
      begin
         case (state_q)
            lse_pkg::S_IDLE:
            begin
               if (hdr_valid_i)
               begin
                  cur_id_q <= hdr_id_i;
                  cur_len_q <= sel_len;
                  err_seen_q <= 1'b0;
                  // Publish from the entry; own header too
                  if (sel_len != '0)
                  begin
                     buf_q <= sel_data;
                     cnt_q <= 4'h1;
                     tx_valid_q <= 1'b1;
                     tx_kind_q <= lse_pkg::TX_DATA;
                     tx_byte_q <= sel_data[7:0];
                     state_q <= lse_pkg::S_PUB;
                  end
                  else
                  begin
                     buf_q <= '0;
                     cnt_q <= '0;
                     state_q <= lse_pkg::S_SUB;
                  end
               end
               // Issue the header for the stored full frame
               else if (htx_start)
               begin
                  cur_id_q <= full_id_q;
                  tx_valid_q <= 1'b1;
                  tx_kind_q <= lse_pkg::TX_BREAK;
                  tx_byte_q <= 8'h00;
                  state_q <= lse_pkg::S_HTX;
               end
            end
            lse_pkg::S_HTX:
            begin
               if (tx_fire)
               begin
                  case (tx_kind_q)
                     lse_pkg::TX_BREAK:
                     begin
                        tx_kind_q <= lse_pkg::TX_SYNC;
                        tx_byte_q <= lse_pkg::SYNC_BYTE;
                     end
                     lse_pkg::TX_SYNC:
                     begin
                        tx_kind_q <= lse_pkg::TX_ID;
                        tx_byte_q <= prot_id;
                     end
                     default:
                     begin
                        tx_valid_q <= 1'b0;
                        state_q <= lse_pkg::S_IDLE;
                     end
                  endcase
               end
            end
            lse_pkg::S_PUB:
            begin
               if (tx_fire)
               begin
                  if (cnt_q == cur_len_q)
                     tx_valid_q <= 1'b0;
                  else
                  begin
                     tx_byte_q <= buf_q[byte_idx +: 8];
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               if (rsp_done_i)
               begin
                  tx_valid_q <= 1'b0;
                  // Own response logged only with self-reception
                  if (self_rx_en_i)
                  begin
                     item_q <= pub_item;
                     state_q <= lse_pkg::S_PUSH;
                  end
                  else
                     state_q <= lse_pkg::S_IDLE;
               end
            end
            lse_pkg::S_SUB:
            begin
               if (rx_valid_i && cnt_q != lse_pkg::MAX_LEN)
               begin
                  buf_q[byte_idx +: 8] <= rx_byte_i;
                  cnt_q <= cnt_q + 4'h1;
               end
               // Header and response merged into one item
               if (rsp_done_i)
               begin
                  item_q <= sub_item;
                  state_q <= lse_pkg::S_PUSH;
               end
            end
            lse_pkg::S_PUSH:
            begin
               // Waits here while the queue is full
               if (fifo_in_ready)
                  state_q <= lse_pkg::S_IDLE;
            end
            default:
               state_q <= lse_pkg::S_IDLE;
         endcase
      end
   end

   // ID of the accepted full frame, held until its header goes out
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         full_id_q <= '0;
      else if (full_acc)
         full_id_q <= wr_id_i;
   end

   // Push raises read-available through the head valid
   lse_fifo #(
      .WIDTH(lse_pkg::ITEM_W),
      .DEPTH(lse_pkg::FIFO_DEPTH)
   ) u_rd_queue (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(state_q == lse_pkg::S_PUSH),
      .in_ready_o(fifo_in_ready),
      .in_data_i(item_q),
      .out_valid_o(rd_valid_o),
      .out_ready_i(rd_ready_i),
      .out_data_o(rd_item_o)
   );

   assign read_avail_o = rd_valid_o;
   assign wr_ready_o = wr_ready_q;
   assign write_ok_o = write_ok_q;
   assign tx_valid_o = tx_valid_q;
   assign tx_kind_o = tx_kind_q;
   assign tx_byte_o = tx_byte_q;
endmodule // lse_response_engine

// ### verification/lse_engine_props.sv
// Port-level assertions for the response engine
`timescale 1ns/1ps
module lse_engine_props (
   input wire logic core_clk_i, // Clock
   input wire logic rstn_i, // Reset
   input wire logic run_i, // Run
   input wire logic wr_valid_i, // Write valid
   input wire logic wr_ready_o, // Write ready
   input wire logic wr_full_i, // Full frame
   input wire logic write_ok_o, // Write ok
   input wire logic write_ok_clr_i, // Ok clear
   input wire logic tx_valid_o, // Field valid
   input wire logic [1:0] tx_kind_o, // Field kind
   input wire logic [7:0] tx_byte_o, // Field byte
   input wire logic tx_ready_i, // Field taken
   input wire logic bus_err_i, // Bus error
   input wire logic rsp_done_i, // Response done
   input wire logic rd_valid_o, // Head valid
   input wire logic rd_ready_i, // Pop
   input wire logic [lse_pkg::ITEM_W-1:0] rd_item_o, // Head
   input wire logic read_avail_o // Avail
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   AST_WR_GAP: assert property (wr_valid_i && wr_ready_o |=> !wr_ready_o)
      else $error("write ready held after take");
   AST_WR_OK: assert property (wr_valid_i && wr_ready_o && !wr_full_i |=> write_ok_o)
      else $error("entry write without success flag");
   AST_OK_STICKY: assert property (write_ok_o && !write_ok_clr_i |=> write_ok_o)
      else $error("success flag lost");
   AST_NO_RUN: assert property (!run_i [*2] |-> !wr_ready_o)
      else $error("write ready while stopped");
   AST_FULL_HDR: assert property (wr_valid_i && wr_ready_o && wr_full_i |->
      ##[1:4] (tx_valid_o && tx_kind_o == 2'h0)) else $error("no break after frame write");
   AST_SYNC_NEXT: assert property (tx_valid_o && tx_ready_i && tx_kind_o == 2'h0 |->
      ##[1:4] (tx_valid_o && tx_kind_o == 2'h1 && tx_byte_o == 8'h55))
      else $error("sync does not follow break");
   AST_PID: assert property (tx_valid_o && tx_kind_o == 2'h2 |->
      tx_byte_o[6] == ^{tx_byte_o[4], tx_byte_o[2:0]} &&
      tx_byte_o[7] == ~^{tx_byte_o[5:3], tx_byte_o[1]}) else $error("bad id parity");
   AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i && !bus_err_i && !rsp_done_i |=>
      tx_valid_o && $stable(tx_kind_o) && $stable(tx_byte_o)) else $error("field dropped");
   AST_RD_HOLD: assert property (rd_valid_o && !rd_ready_i |=>
      rd_valid_o && $stable(rd_item_o)) else $error("head changed unpopped");
   AST_AVAIL: assert property (read_avail_o == rd_valid_o)
      else $error("avail differs from head valid");
endmodule // lse_engine_props
bind lse_response_engine lse_engine_props u_props (.core_clk_i, .rstn_i, .run_i, .wr_valid_i,
   .wr_ready_o, .wr_full_i, .write_ok_o, .write_ok_clr_i, .tx_valid_o, .tx_kind_o, .tx_byte_o,
   .tx_ready_i, .rd_valid_o, .rd_ready_i, .rd_item_o, .read_avail_o, .bus_err_i,
   .rsp_done_i);

// ### verification/lse_bus_model.sv
// Bit layer and bus model: takes fields, echoes own headers, plays pulses
`timescale 1ns/1ps
module lse_bus_model (
   input wire logic core_clk_i, // Clock
   input wire logic slow_i, // Stall every other cycle
   input wire logic tx_valid_i, // Field valid
   input wire logic [1:0] tx_kind_i, // Field kind
   input wire logic [7:0] tx_byte_i, // Field byte
   output logic tx_ready_o, // Field taken
   output logic hdr_valid_o, // Header pulse
   output logic [5:0] hdr_id_o, // Header id
   output logic rx_valid_o, // Byte pulse
   output logic [7:0] rx_byte_o, // Byte
   output logic done_o, // Response done
   output logic err_o, // Bus error
   output logic [2:0] err_code_o // Error code
);
   logic [9:0] txq[$];
   logic st_q = 1'b0;
   initial
   begin
      {hdr_valid_o, rx_valid_o, done_o, err_o, tx_ready_o} = 5'h0;
      {hdr_id_o, rx_byte_o, err_code_o} = 17'h1FFFF;
   end
   always @(negedge core_clk_i)
   begin
      st_q <= !st_q;
      tx_ready_o <= !slow_i || st_q;
   end
   // echo own header once id is out
   always @(posedge core_clk_i)
      if (tx_valid_i && tx_ready_o)
      begin
         txq.push_back({tx_kind_i, tx_byte_i});
         if (tx_kind_i == 2'h2)
            pulse(2'h0, {2'h0, tx_byte_i[5:0]});
      end
   // collisions arrive as error pulses; idle lines carry inverted data
   task automatic pulse(input logic [1:0] k, input logic [7:0] v);
      @(negedge core_clk_i);
      {hdr_valid_o, rx_valid_o, done_o, err_o} = 4'h8 >> k;
      {hdr_id_o, rx_byte_o, err_code_o} = {v[5:0], v, v[2:0]};
      @(negedge core_clk_i);
      {hdr_valid_o, rx_valid_o, done_o, err_o} = 4'h0;
      {hdr_id_o, rx_byte_o, err_code_o} = ~{v[5:0], v, v[2:0]};
   endtask
endmodule // lse_bus_model

// ### verification/tb_top.sv
// Self-checking bench for the response engine
`timescale 1ns/1ps
module tb_top;
   localparam int IW = lse_pkg::ITEM_W;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic run_i = 1'b0;
   logic self_rx_en_i = 1'b1;
   logic log_err_en_i = 1'b1;
   logic wr_valid_i = 1'b0;
   logic wr_full_i = 1'b0;
   logic [5:0] wr_id_i = 6'h0;
   logic [3:0] wr_len_i = 4'h0;
   logic [63:0] wr_data_i = 64'h0;
   logic write_ok_clr_i = 1'b0;
   logic rd_ready_i = 1'b0;
   logic hold_rd = 1'b0;
   logic slow = 1'b0;
   logic pop_now = 1'b0;
   logic [lse_pkg::ITEM_W-1:0] exp_item;
   logic wr_ready_o, write_ok_o, tx_valid_o, tx_ready_i, rd_valid_o, read_avail_o;
   logic hdr_valid_i, rx_valid_i, rsp_done_i, bus_err_i;
   logic [5:0] hdr_id_i;
   logic [7:0] rx_byte_i, tx_byte_o;
   logic [2:0] bus_err_code_i;
   logic [1:0] tx_kind_o;
   logic [IW-1:0] rd_item_o;
   logic [IW-1:0] expq[$];
   logic [31:0] rng = 32'hC45B;
   int n_mismatch = 0;
   int n_tests = 0;
   always #4 core_clk_i = ~core_clk_i;
   lse_response_engine DUT (.core_clk_i, .rstn_i, .run_i, .self_rx_en_i, .log_err_en_i,
      .wr_valid_i, .wr_ready_o, .wr_full_i, .wr_id_i, .wr_len_i, .wr_data_i, .write_ok_o,
      .write_ok_clr_i, .hdr_valid_i, .hdr_id_i, .rx_valid_i, .rx_byte_i, .rsp_done_i,
      .bus_err_i, .bus_err_code_i, .tx_valid_o, .tx_kind_o, .tx_byte_o, .tx_ready_i,
      .rd_valid_o, .rd_ready_i, .rd_item_o, .read_avail_o);
   lse_bus_model bus (.core_clk_i, .slow_i(slow), .tx_valid_i(tx_valid_o),
      .tx_kind_i(tx_kind_o), .tx_byte_i(tx_byte_o), .tx_ready_o(tx_ready_i),
      .hdr_valid_o(hdr_valid_i), .hdr_id_o(hdr_id_i), .rx_valid_o(rx_valid_i),
      .rx_byte_o(rx_byte_i), .done_o(rsp_done_i), .err_o(bus_err_i),
      .err_code_o(bus_err_code_i));
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic [IW-1:0] mk(logic k, logic [5:0] id, logic [3:0] n,
         logic [63:0] d, logic [2:0] e);
      return {k, id, n, d, e};
   endfunction
   // Error items: only kind and code; full items: bytes beyond length ignored
   function automatic logic [IW-1:0] msk(logic [IW-1:0] it);
      logic e;
      e = it[IW-1];
      return {1'b1, {10{!e}}, e ? 64'h0 : ~(64'hFFFFFFFFFFFFFFFF << (8 * it[70:67])), 3'h7};
   endfunction
   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Pop decided and head compared while it stands, before the edge that takes it
   always @(negedge core_clk_i)
   begin
      pop_now = !hold_rd && xs() > 32'h7FFFFFFF;
      rd_ready_i <= pop_now;
      if (rstn_i && rd_valid_o && pop_now)
      begin
         if (expq.size() == 0)
            check(1'b0, "unexpected item");
         else
         begin
            exp_item = expq.pop_front();
            check(((rd_item_o ^ exp_item) & msk(exp_item)) == '0, "item");
         end
      end
   end
   task automatic await(input int sel, input int n);
      for (int i = 0; i < 300; i++)
      begin
         @(negedge core_clk_i);
         if (sel == 0 ? bus.txq.size() >= n : sel == 1 ? expq.size() == 0 : write_ok_o)
            return;
      end
      check(1'b0, "wait ran out");
      final_report();
   endtask
   task automatic wr(input logic f, input logic [5:0] id, input logic [3:0] n,
         input logic [63:0] d);
      @(negedge core_clk_i);
      write_ok_clr_i = 1'b1;
      @(negedge core_clk_i);
      write_ok_clr_i = 1'b0;
      {wr_valid_i, wr_full_i, wr_id_i, wr_len_i, wr_data_i} = {1'b1, f, id, n, d};
      for (int i = 0; i < 100 && wr_ready_o !== 1'b1; i++)
         @(negedge core_clk_i);
      if (wr_ready_o !== 1'b1)
      begin
         check(1'b0, "write ready ran out");
         final_report();
      end
      @(negedge core_clk_i);
      wr_valid_i = 1'b0;
      if (!f)
         await(2, 0);
   endtask
   task automatic sub(input logic [5:0] id, input logic [63:0] d);
      expq.push_back(mk(1'b0, id, 4'h8, d, 3'h0));
      bus.pulse(2'h0, {2'h0, id});
      for (int i = 0; i < 8; i++)
         bus.pulse(2'h1, d[8*i +: 8]);
      bus.pulse(2'h2, 8'h00);
      repeat (4) @(negedge core_clk_i);
   endtask
   task automatic frame(input logic f, input logic [5:0] id, input logic [3:0] n,
         input logic [63:0] d, input logic [2:0] e);
      int h;
      h = f ? 3 : 0;
      bus.txq.delete();
      if (e != 0)
         expq.push_back(mk(1'b1, id, 4'h0, 64'h0, e));
      else if (self_rx_en_i)
         expq.push_back(mk(1'b0, id, n, d, 3'h0));
      if (f)
         wr(1'b1, id, n, d);
      else
         bus.pulse(2'h0, {2'h0, id});
      await(0, h + n);
      if (f)
         check(bus.txq[0][9:8] === 2'h0 && bus.txq[1] === 10'h155 &&
            bus.txq[2][9:8] === 2'h2 && bus.txq[2][5:0] === id, "header");
      for (int i = 0; i < n; i++)
         check(bus.txq[h+i] === {2'h3, d[8*i +: 8]}, "published byte");
      bus.pulse(e != 0 ? 2'h3 : 2'h2, {5'h0, e});
      if (f)
         await(2, 0);
      check(bus.txq.size() == h + n, "field count");
      repeat (4) @(negedge core_clk_i);
   endtask
   initial
   begin
      logic [63:0] d;
      repeat (10) @(negedge core_clk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      run_i = 1'b1; // configured before start
      d = {xs(), xs()};
      wr(1'b0, 6'h05, 4'h0, d);
      sub(6'h05, d);
      sub(6'h09, ~d);
      $display("subscribe test ended");
      for (int k = 1; k <= 8; k++)
      begin
         d = {xs(), xs()};
         self_rx_en_i = k[0];
         slow = d[1];
         wr(1'b0, 6'h0A, k[3:0], d);
         frame(1'b0, 6'h0A, k[3:0], d, 3'h0);
      end
      $display("publish test ended");
      self_rx_en_i = 1'b1;
      frame(1'b1, 6'h14, 4'h2, d, 3'h0);
      frame(1'b0, 6'h14, 4'h2, d, 3'h0);
      frame(1'b1, 6'h15, 4'h1, ~d, 3'h6);
      $display("frame write test ended");
      expq.push_back(mk(1'b1, 6'h05, 4'h0, 64'h0, 3'h3));
      bus.pulse(2'h0, 8'h05);
      bus.pulse(2'h1, d[7:0]);
      bus.pulse(2'h3, 8'h03);
      bus.pulse(2'h3, 8'h05);
      bus.pulse(2'h2, 8'h00);
      repeat (4) @(negedge core_clk_i);
      sub(6'h05, d);
      log_err_en_i = 1'b0;
      bus.pulse(2'h0, 8'h05);
      bus.pulse(2'h3, 8'h02);
      repeat (4) @(negedge core_clk_i);
      sub(6'h05, ~d);
      $display("error test ended");
      // Drain first so the four items below exactly fill the queue
      await(1, 0);
      repeat (2) @(negedge core_clk_i);
      hold_rd = 1'b1;
      for (int k = 0; k < 4; k++)
         sub(k[5:0] + 6'h20, {xs(), xs()});
      check(read_avail_o === 1'b1, "avail low with items");
      hold_rd = 1'b0;
      await(1, 0);
      @(negedge core_clk_i);
      check(read_avail_o === 1'b0, "avail stuck high");
      $display("queue test ended");
      run_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      check(wr_ready_o === 1'b0, "write ready while stopped");
      $display("stop test ended");
      final_report();
   end
endmodule // tb_top
